// >>> logic/i2cbr_top.sv
// bus-collision detection for repeated start and stop, and the shared baud generator
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "i2cbr_consts.svh"
// Function
// - repeated start: sda low at scl rise collides
// - repeated start: scl falls before sda low collides
// - repeated start: sda high, count, release scl, sample
// - sda high: reload; early sda fall is fine
// - scl fall before count ends, sda free collides
// - both high at expiry: sda low, count, scl low
// - stop: sda still low after count collides
// - stop: scl low before sda high collides
// - stop: sda low, release scl, count, sample sda
// - one baud generator serves i2c and spi
// - buffer write starts the baud generator
// - generator stops, clock holds last level
// - reload twice per serial clock period
// - clock equals osc over four times reload+1
// - collision sets flag and returns to idle
// - collision aborts, releases lines, clears enable
module i2cbr_top
    import i2cbr_pkg::*;
#(
    parameter int RELOAD_W = 8 // reload register width
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [3:0] wb_adr_i, // word address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic sda_i, // sda line level
    output logic sda_o, // sda drive value
    output logic sda_oe, // sda pulled low while high
    input wire logic scl_i, // scl line level
    output logic scl_o, // scl drive value
    output logic scl_oe, // scl pulled low while high
    output logic spi_sck, // spi serial clock
    output logic spi_sdo, // spi serial data out
    output logic irq // level interrupt
);
    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    i2cbr_state_e state; // sequence state
    i2cbr_state_e next_state; // next sequence state
    logic [RELOAD_W-1:0] baud_reload_value; // reload register
    logic [7:0] xfer_buffer; // transmit shift buffer
    logic repeated_start_enable; // repeated start request
    logic stop_enable; // stop request
    logic spi_mode; // spi instead of i2c
    logic [1:0] int_status; // sticky flags
    logic [1:0] int_mask; // flag enables
    logic [RELOAD_W:0] baud_counter; // half-period down counter
    logic [4:0] half_cnt; // byte half periods left
    logic sda_low; // we pull sda
    logic scl_low; // we pull scl
    logic next_sda_low; // next sda pull
    logic next_scl_low; // next scl pull
    logic brg_load; // reload strobe
    logic set_col; // collision event
    logic set_evt; // sequence done event
    logic sda_m, sda_s, scl_m, scl_s; // synchronisers
    logic scl_s_d; // delayed scl for edge
    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire req = wb_cyc_i & wb_stb_i; // live request
    wire wr_go = req & wb_we_i & wb_ack_o & wb_sel_i[0]; // write commits with ack
    wire wr_reload = wr_go & (wb_adr_i == `I2CBR_OFS_RELOAD);
    wire wr_buffer = wr_go & (wb_adr_i == `I2CBR_OFS_BUFFER);
    wire wr_ctrl = wr_go & (wb_adr_i == `I2CBR_OFS_CTRL);
    wire wr_status = wr_go & (wb_adr_i == `I2CBR_OFS_STATUS);
    wire wr_mask = wr_go & (wb_adr_i == `I2CBR_OFS_MASK);
    wire idle = (state == I2CBR_IDLE);
    wire brg_zero = (baud_counter == '0); // count expired
    wire scl_fell = scl_s_d & ~scl_s;
    wire start_tx = wr_buffer & idle & ~repeated_start_enable & ~stop_enable;
    wire [31:0] rd_word = (wb_adr_i == `I2CBR_OFS_RELOAD) ? 32'(baud_reload_value) :
        (wb_adr_i == `I2CBR_OFS_BUFFER) ? {24'h0, xfer_buffer} :
        (wb_adr_i == `I2CBR_OFS_CTRL) ? {29'h0, spi_mode, stop_enable,
                                          repeated_start_enable} :
        (wb_adr_i == `I2CBR_OFS_STATUS) ? {30'h0, int_status} :
        (wb_adr_i == `I2CBR_OFS_MASK) ? {30'h0, int_mask} :
        (wb_adr_i == `I2CBR_OFS_STATE) ? {21'h0, state} : 32'h0;
    wire [1:0] int_set = {set_evt, set_col};
    // ------------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------------
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe = sda_low & ~spi_mode;
    assign scl_oe = scl_low & ~spi_mode;
    assign spi_sck = ~scl_low & spi_mode; // same generator drives spi clock
    assign spi_sdo = ~sda_low & spi_mode;
    assign irq = |(int_status & int_mask);
    // ------------------------------------------------------------------
    // wishbone slave: one wait, then ack
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= rd_word;
        end
    end
    // ------------------------------------------------------------------
    // line synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_s_d <= 1'b1;
        end else begin
            sda_m <= sda_i;
            sda_s <= sda_m;
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_s_d <= scl_s;
        end
    end
    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            baud_reload_value <= RELOAD_W'(`I2CBR_RELOAD_RST);
            int_mask <= 2'h0;
            spi_mode <= 1'b0;
        end else begin
            if (wr_reload) baud_reload_value <= wb_dat_i[RELOAD_W-1:0];
            if (wr_mask) int_mask <= wb_dat_i[1:0];
            if (wr_ctrl & idle) spi_mode <= wb_dat_i[`I2CBR_CTRL_SPI];
        end
    end
    // sticky flags: set beats a write-one clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_status <= 2'h0;
        end else begin
            int_status <= (int_status & ~({2{wr_status}} & wb_dat_i[1:0])) | int_set;
        end
    end
    // sequence enables: set by software, cleared on end or collision
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            repeated_start_enable <= 1'b0;
            stop_enable <= 1'b0;
        end else if (set_col || set_evt) begin
            repeated_start_enable <= 1'b0;
            stop_enable <= 1'b0;
        end else if (wr_ctrl & idle) begin
            repeated_start_enable <= wb_dat_i[`I2CBR_CTRL_REPEATED_START_ENABLE];
            stop_enable <= wb_dat_i[`I2CBR_CTRL_STOPEN] & ~wb_dat_i[`I2CBR_CTRL_REPEATED_START_ENABLE];
        end
    end
    // ------------------------------------------------------------------
    // baud counter: 2*(reload+1) cycles per half period
    // ------------------------------------------------------------------
    // the counter holds reload*2+1 after a load and stops at zero
    // loads land at the start of each half period, two per clock period
    // a zero count is the expiry the counting steps wait for; the release and pull steps wait on line levels
    // once no step reloads it, the counter rests at zero by itself
    // the pins then keep whatever level the last step left them at
    // reload values below three give too short a half period for
    // the two-flop line latency; hardware does not refuse them
    // the same counter times spi bytes, so one reload serves both modes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            baud_counter <= '0;
        end else if (brg_load) begin
            baud_counter <= {baud_reload_value, 1'b1};
        end else if (!brg_zero) begin
            baud_counter <= baud_counter - 1'b1;
        end
    end
    // ------------------------------------------------------------------
    // state, pin pulls, byte shifter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= I2CBR_IDLE;
            sda_low <= 1'b0;
            scl_low <= 1'b0;
        end else begin
            state <= next_state;
            sda_low <= next_sda_low;
            scl_low <= next_scl_low;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            xfer_buffer <= 8'h0;
            half_cnt <= 5'h0;
        end else if (start_tx) begin
            xfer_buffer <= wb_dat_i[7:0];
            half_cnt <= `I2CBR_HALVES_PER_BYTE;
        end else if (state == I2CBR_TX && brg_zero) begin
            half_cnt <= half_cnt - 5'h1;
            if (!scl_low) xfer_buffer <= {xfer_buffer[6:0], 1'b0};
        end
    end
    // ------------------------------------------------------------------
    // sequence control
    // ------------------------------------------------------------------
    // one state machine walks the byte, repeated start and stop steps
    // every line test uses the synchronised levels, never the raw pins
    // so each decision lags the wire by two clocks
    //
    // repeated start walk:
    //   release sda and wait for it to read high
    //   load the counter and wait for expiry
    //   release scl and wait for it to read high
    //   sda low at that point means another master sends a zero
    //   otherwise count again with both lines high
    //   scl falling while sda is still free means a rival one bit
    //   an early sda fall during this count is not a collision
    //   at expiry pull sda, count once more, then pull scl
    //   the last pull of scl ignores the line level on purpose
    //
    // stop walk:
    //   pull sda and wait for it to read low
    //   release scl and wait for it to read high
    //   count with scl high; scl low here is a rival clock
    //   release sda and count once more
    //   sda still low at expiry means a rival holds it
    //   otherwise the stop is done and the event flag is raised
    //
    // byte walk:
    //   a buffer write while idle pulls scl and shows the first bit
    //   sixteen half periods shift eight bits out, msb first
    //   sda only changes in the half period where scl is pulled
    //   the byte ends with scl held low for the next step
    //
    // collision handling:
    //   any collision raises the collision flag the same cycle
    //   both lines are let go and the machine drops to idle
    //   the request bits are cleared so software must ask again
    //   a byte in flight is not checked against the line here
    //
    // the override at the bottom keeps the collision path in one place
    // so every state shares the same abort behaviour
    always_comb begin
        next_state = state;
        next_sda_low = sda_low;
        next_scl_low = scl_low;
        brg_load = 1'b0;
        set_col = 1'b0;
        set_evt = 1'b0;
        case (state)
            I2CBR_IDLE: begin
                if (start_tx) begin
                    next_state = I2CBR_TX;
                    brg_load = 1'b1;
                    next_scl_low = 1'b1;
                    next_sda_low = ~wb_dat_i[7];
                end else if (repeated_start_enable) begin
                    next_state = I2CBR_RS_REL;
                    next_sda_low = 1'b0;
                end else if (stop_enable) begin
                    next_state = I2CBR_SP_LOW;
                    next_sda_low = 1'b1;
                end
            end
            I2CBR_TX: begin
                if (brg_zero) begin
                    if (half_cnt == 5'h1) begin
                        next_state = I2CBR_IDLE;
                        next_scl_low = 1'b1;
                        set_evt = 1'b1;
                    end else begin
                        brg_load = 1'b1;
                        next_scl_low = ~scl_low;
                        if (!scl_low) next_sda_low = ~xfer_buffer[6];
                    end
                end
            end
            I2CBR_RS_REL: begin
                if (sda_s) begin
                    next_state = I2CBR_RS_CNT1;
                    brg_load = 1'b1;
                end
            end
            I2CBR_RS_CNT1: begin
                if (brg_zero) begin
                    next_state = I2CBR_RS_SCLH;
                    next_scl_low = 1'b0;
                end
            end
            I2CBR_RS_SCLH: begin
                if (scl_s && !sda_s) begin
                    set_col = 1'b1;
                end else if (scl_s) begin
                    next_state = I2CBR_RS_CNT2;
                    brg_load = 1'b1;
                end
            end
            I2CBR_RS_CNT2: begin
                if (scl_fell && sda_s) begin
                    set_col = 1'b1;
                end else if (brg_zero) begin
                    next_state = I2CBR_RS_CNT3;
                    next_sda_low = 1'b1;
                    brg_load = 1'b1;
                end
            end
            I2CBR_RS_CNT3: begin
                if (brg_zero) begin
                    next_state = I2CBR_IDLE;
                    next_scl_low = 1'b1;
                    set_evt = 1'b1;
                end
            end
            I2CBR_SP_LOW: begin
                if (!sda_s) begin
                    next_state = I2CBR_SP_SCLH;
                    next_scl_low = 1'b0;
                end
            end
            I2CBR_SP_SCLH: begin
                if (scl_s) begin
                    next_state = I2CBR_SP_CNT;
                    brg_load = 1'b1;
                end
            end
            I2CBR_SP_CNT: begin
                if (!scl_s) begin
                    set_col = 1'b1;
                end else if (brg_zero) begin
                    next_state = I2CBR_SP_REL;
                    next_sda_low = 1'b0;
                    brg_load = 1'b1;
                end
            end
            I2CBR_SP_REL: begin
                if (!scl_s && !sda_s) begin
                    set_col = 1'b1;
                end else if (brg_zero && !sda_s) begin
                    set_col = 1'b1;
                end else if (brg_zero) begin
                    next_state = I2CBR_IDLE;
                    set_evt = 1'b1;
                end
            end
            default: begin
                next_state = I2CBR_IDLE;
                next_sda_low = 1'b0;
                next_scl_low = 1'b0;
            end
        endcase
        if (set_col) begin
            next_state = I2CBR_IDLE;
            next_sda_low = 1'b0;
            next_scl_low = 1'b0;
        end
    end
endmodule

// >>> logic/i2cbr_consts.svh
// offsets, field positions, reset values and timing counts of the collision/baud block
`ifndef I2CBR_CONSTS_SVH
`define I2CBR_CONSTS_SVH
// ----------------------------------------------------------------------
// register word offsets
// ----------------------------------------------------------------------
`define I2CBR_OFS_RELOAD 4'h0
`define I2CBR_OFS_BUFFER 4'h1
`define I2CBR_OFS_CTRL 4'h2
`define I2CBR_OFS_STATUS 4'h3
`define I2CBR_OFS_MASK 4'h4
`define I2CBR_OFS_STATE 4'h5
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define I2CBR_CTRL_REPEATED_START_ENABLE 0
`define I2CBR_CTRL_STOPEN 1
`define I2CBR_CTRL_SPI 2
`define I2CBR_INT_COL 0
`define I2CBR_INT_EVT 1
// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define I2CBR_RELOAD_RST 8'h09
`define I2CBR_HALVES_PER_BYTE 5'h10
`endif

// >>> logic/i2cbr_pkg.sv
// types shared by the collision/baud block
package i2cbr_pkg;
    // ------------------------------------------------------------------
    // sequence states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [10:0] {
        I2CBR_IDLE = 11'h001, // nothing running
        I2CBR_RS_REL = 11'h002, // sda released, waiting for it high
        I2CBR_RS_CNT1 = 11'h004, // first repeated-start count
        I2CBR_RS_SCLH = 11'h008, // scl released, waiting for it high
        I2CBR_RS_CNT2 = 11'h010, // count with scl high
        I2CBR_RS_CNT3 = 11'h020, // sda low, count before scl low
        I2CBR_SP_LOW = 11'h040, // sda driven low, waiting for it
        I2CBR_SP_SCLH = 11'h080, // scl released, waiting for it high
        I2CBR_SP_CNT = 11'h100, // count before releasing sda
        I2CBR_SP_REL = 11'h200, // sda released, count then sample
        I2CBR_TX = 11'h400 // byte shifting
    } i2cbr_state_e;
endpackage

// >>> tb/i2cbr_properties.sv
// port-level checker for the collision and baud block
`timescale 1ns/1ps
module i2cbr_properties (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // bus write
    input wire logic [3:0] wb_adr_i, // word address
    input wire logic wb_ack_o, // bus acknowledge
    input wire logic sda_i, // sda level
    input wire logic sda_o, // sda drive value
    input wire logic sda_oe, // sda pull
    input wire logic scl_o, // scl drive value
    input wire logic scl_oe, // scl pull
    input wire logic spi_sck, // spi clock
    input wire logic spi_sdo, // spi data
    input wire logic irq // level interrupt
);
    // ------------------------------------------------------------
    // one clock, one reset for every property
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    open_drain_a: assert property (!sda_o && !scl_o)
        else $error("line driven high");
    spi_quiet_a: assert property (spi_sck || spi_sdo |-> !sda_oe && !scl_oe)
        else $error("i2c lines pulled in spi mode");
    scl_hold_a: assert property ($changed(scl_oe) |=> $stable(scl_oe) [*3])
        else $error("scl half period too short");
    stop_order_a: assert property ($fell(scl_oe) && sda_oe |-> !$past(sda_i, 2))
        else $error("scl released before sda seen low");
    irq_clear_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
        else $error("interrupt dropped without a write");
    buf_start_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h1 && !sda_oe
        && !scl_oe |=> ##[1:40] (scl_oe || spi_sck))
        else $error("buffer write did not start the clock");
endmodule
bind i2cbr_top i2cbr_properties chk (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
    .spi_sck(spi_sck), .spi_sdo(spi_sdo), .irq(irq));

// >>> tb/i2cbr_partner.sv
// far side of the bus: pull-ups and another master that may hold a line low
`timescale 1ns/1ps
module i2cbr_partner (
    input wire logic sda_oe, // block pulls sda
    input wire logic scl_oe, // block pulls scl
    input wire logic pull_sda, // other master holds sda low
    input wire logic pull_scl, // other master holds scl low
    output logic sda, // resolved sda level
    output logic scl // resolved scl level
);
    // open-drain wires: any pull wins, else the pull-up
    assign sda = !(sda_oe || pull_sda);
    assign scl = !(scl_oe || pull_scl);
endmodule

// >>> tb/i2cbr_top_bench.sv
// self-checking bench for the collision and baud block
`timescale 1ns/1ps
module i2cbr_top_bench;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    localparam logic [7:0] RL = 8'h03; // reload, half period 2*(RL+1)
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe, spi_sck, spi_sdo, irq;
    logic pull_sda = 1'b0, pull_scl = 1'b0; // other master's pulls
    int mismatches = 0, total_checks = 0;
    i2cbr_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe(sda_oe), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .spi_sck(spi_sck),
        .spi_sdo(spi_sdo), .irq(irq));
    i2cbr_partner far (.sda_oe(sda_oe), .scl_oe(scl_oe), .pull_sda(pull_sda),
        .pull_scl(pull_scl), .sda(sda_i), .scl(scl_i));
    // clock source
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d,
        output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, we, a};
        wb_dat_i <= {24'h0, d};
        for (n = 0; n < 50; n++) begin
            @(negedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 50) check(wb_ack_o, 1'b1);
        q = wb_dat_o;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(negedge clk_sys);
    endtask
    // poll the state register until idle
    task automatic wait_idle;
        logic [31:0] q;
        for (int n = 0; n < 300; n++) begin
            wb(1'b0, 4'h5, 8'h00, q);
            if (q[10:0] === 11'h001) break;
        end
        check(q, 32'h1);
    endtask
    // wait for the block to release sda (0) or scl (1)
    task automatic wait_rel(input int w);
        for (int n = 0; n < 500 && (w ? scl_oe : sda_oe) !== 1'b0; n++) @(negedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic regs;
        logic [31:0] q;
        wb(1'b0, 4'h0, 8'h00, q);
        check(q, 32'h9);
        wb(1'b0, 4'h7, 8'h00, q);
        check(q, 32'h0);
        wb(1'b1, 4'h0, RL, q);
        wb(1'b0, 4'h0, 8'h00, q);
        check(q, {24'h0, RL});
        wb(1'b1, 4'h4, 8'h03, q);
        check(irq, 1'b0);
    endtask
    // byte out, then a sequence with optional pulls by the other master
    task automatic seq(input logic [7:0] c, input int w, input int d, input logic ps,
        input logic pc, input logic [31:0] st, input logic [1:0] ln);
        logic [31:0] q;
        int n;
        wb(1'b1, 4'h1, 8'h5A, q);
        for (n = 0; n < 100 && scl_oe !== 1'b1; n++) @(negedge clk_sys);
        for (n = 0; n < 100 && scl_oe === 1'b1; n++) @(negedge clk_sys);
        check(n, 2 * (RL + 1));
        wait_idle;
        check(scl_oe, 1'b1);
        wb(1'b1, 4'h3, 8'h03, q);
        wb(1'b1, 4'h2, c, q);
        wait_rel(w);
        repeat (d) @(posedge clk_sys);
        {pull_sda, pull_scl} <= {ps, pc};
        wait_idle;
        wb(1'b0, 4'h3, 8'h00, q);
        check(q, st);
        check({sda_oe, scl_oe}, ln);
        wb(1'b0, 4'h2, 8'h00, q);
        check(q, 32'h0);
        check(irq, 1'b1);
        wb(1'b1, 4'h4, 8'h00, q);
        check(irq, 1'b0);
        wb(1'b1, 4'h4, 8'h03, q);
        wb(1'b1, 4'h3, 8'h03, q);
        check(irq, 1'b0);
        {pull_sda, pull_scl} <= 2'b00;
    endtask
    // spi byte on the same generator; control write while busy is ignored
    task automatic spi_run;
        logic [31:0] q;
        logic v;
        int n;
        wb(1'b1, 4'h2, 8'h04, q);
        wb(1'b1, 4'h1, 8'h5A, q);
        v = spi_sck;
        for (n = 0; n < 100 && spi_sck === v; n++) @(negedge clk_sys);
        v = spi_sck;
        for (n = 0; n < 100 && spi_sck === v; n++) @(negedge clk_sys);
        check(n, 2 * (RL + 1));
        wb(1'b1, 4'h2, 8'h01, q);
        wait_idle;
        wb(1'b0, 4'h2, 8'h00, q);
        check(q, 32'h4);
        wb(1'b1, 4'h2, 8'h00, q);
        wb(1'b1, 4'h3, 8'h03, q);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        regs;
        seq(8'h01, 1, 0, 1'b0, 1'b0, 32'h2, 2'b11);
        seq(8'h01, 0, 3, 1'b1, 1'b0, 32'h1, 2'b00);
        seq(8'h01, 1, 5, 1'b0, 1'b1, 32'h1, 2'b00);
        seq(8'h02, 1, 0, 1'b0, 1'b0, 32'h2, 2'b00);
        seq(8'h02, 1, 0, 1'b1, 1'b0, 32'h1, 2'b00);
        seq(8'h02, 1, 5, 1'b0, 1'b1, 32'h1, 2'b00);
        spi_run;
        close_out;
    end
    initial begin
        #5000000;
        mismatches++;
        close_out;
    end
endmodule
